// ---- hdl/tcc_pkg.sv ----
/*
 * shared constants and types for the two-channel capture/compare block:
 * register byte offsets, status/control layout, edge/level codes, channel
 * modes and the bundle that carries the shared counter's state.
 * assumes a classic wishbone slave with 32-bit data, one register per word.
 */
package tcc_pkg;

    // register byte offsets, one aligned word each, data in bits 7:0
    localparam logic [7:0] ADR_SC0 = 8'h00;
    localparam logic [7:0] ADR_SC1 = 8'h04;
    localparam logic [7:0] ADR_V0H = 8'h08;
    localparam logic [7:0] ADR_V0L = 8'h0c;
    localparam logic [7:0] ADR_V1H = 8'h10;
    localparam logic [7:0] ADR_V1L = 8'h14;

    // reset values
    localparam logic [7:0]  SC_RESET  = 8'h00;
    localparam logic [15:0] VAL_RESET = 16'h0000;

    // edge/level select encodings
    localparam logic [1:0] ELS_OFF  = 2'b00;
    localparam logic [1:0] ELS_RISE = 2'b01;
    localparam logic [1:0] ELS_FALL = 2'b10;
    localparam logic [1:0] ELS_BOTH = 2'b11;

    // stages in the pin synchroniser
    localparam int SYNC_STAGES = 3;

    // channel status/control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       channel_event_flag;
        logic       channel_irq_enable;
        logic       buffered_mode_select;
        logic       mode_select_low;
        logic [1:0] edge_level_select;
        logic       toggle_on_wrap;
        logic       full_duty_force;
    } tcc_sc_t;

    // decoded channel function
    typedef enum logic [2:0] {
        TCC_MODE_OFF    = 3'b000,
        TCC_MODE_PRESET = 3'b001,
        TCC_MODE_CAP    = 3'b010,
        TCC_MODE_CMP    = 3'b011,
        TCC_MODE_BUFF   = 3'b100
    } tcc_mode_t;

    // state of the shared counter, all on mclk
    typedef struct packed {
        logic [15:0] value;
        logic        tick;
        logic        wrap;
        logic        halt;
        logic        brk;
    } tcc_cnt_t;

endpackage : tcc_pkg

// ---- hdl/tcc_capture_compare.sv ----
/*
 * two-channel input capture / output compare / pwm logic beside a shared
 * 16-bit modulo counter, with its registers on a classic wishbone slave.
 * assumes the counter, prescaler and modulo logic sit outside and present
 * their state on cnt_i, synchronous to mclk; channel pins are external.
 */
`timescale 1ns/100ps

// Operation
// - capture channel sets its event flag on the selected pin edge.
// - compare channel sets its event flag when counter equals channel value.
// - flag clears by status read with flag set, then zero write; events win.
// - writing one to the flag changes nothing; reset clears the flag.
// - interrupt request only while enable and flag are both set.
// - channel 0 buffered bit disables channel 1 control and frees its pin.
// - with edge/level nonzero, low mode bit picks compare or capture.
// - with edge/level zero, low mode bit presets level: one low, zero high.
// - edge/level zero leaves the pin to the port; drive only once enabled.
// - capture codes: 01 rising, 10 falling, 11 both edges.
// - compare codes: 00 flag only, 01 toggle, 10 low, 11 high.
// - toggle-on-wrap toggles compare output at each overflow; reset clears.
// - overflow toggle takes precedence over a coincident compare.
// - full duty force with toggle-on-wrap gives 100% duty, next period.
// - value registers hold captured counter or compare value.
// - reading capture high byte blocks captures until low byte read.
// - writing compare high byte blocks compares and flag until low written.
// - reset clears edge/level and low mode bits, pins disconnected.
// - debug break blocks all input captures.
// - counter halt blocks input captures while set.
// - counter wrap marks the pwm period for the channels.
module tcc_capture_compare
    import tcc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire tcc_cnt_t    cnt_i,
    input  wire logic [1:0]  pin_in,
    output logic      [1:0]  pin_out,
    output logic      [1:0]  pin_oe,
    output logic      [1:0]  irq
);

    tcc_sc_t     sc_q    [2];
    tcc_sc_t     sc_d    [2];
    logic [15:0] val_q   [2];
    logic [15:0] val_d   [2];
    logic [1:0]  armed_q, armed_d;
    logic [1:0]  rlock_q, rlock_d;
    logic [1:0]  wlock_q, wlock_d;
    logic [1:0]  fmax_q,  fmax_d;
    logic [1:0]  out_d,   oe_d,  irq_d;
    logic        bsel_q,  bsel_d;
    logic [1:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic        ack_d;
    logic [31:0] dat_d;

    tcc_mode_t   mode_w  [2];
    logic [1:0]  cap_ev, hit, wrap_ev, rise, fall;
    logic [15:0] cmpval  [2];
    logic        req, rd, wr, buf0;
    tcc_sc_t     wd;

    // channel function from its control bits
    function automatic tcc_mode_t chan_mode(input tcc_sc_t s, input logic is_ch1,
                                            input logic b0);
        if (is_ch1 && b0) return TCC_MODE_OFF;
        if (s.edge_level_select == ELS_OFF) return TCC_MODE_PRESET;
        if (!is_ch1 && s.buffered_mode_select) return TCC_MODE_BUFF;
        if (s.mode_select_low) return TCC_MODE_CMP;
        return TCC_MODE_CAP;
    endfunction : chan_mode

    // bus request decode; a request is taken once, in the cycle before ack
    assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd   = req && !wb_we_i;
    assign wr   = req && wb_we_i && wb_sel_i[0];
    assign buf0 = sc_q[0].buffered_mode_select;
    assign wd   = tcc_sc_t'(wb_dat_i[7:0]);

    // event detection per channel from current state
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            mode_w[c] = chan_mode(sc_q[c], c == 1, buf0);
            rise[c] = (s2_q[c] == s3_q[c]) && s3_q[c] && !lvl_q[c];
            fall[c] = (s2_q[c] == s3_q[c]) && !s3_q[c] && lvl_q[c];
            cap_ev[c] = (mode_w[c] == TCC_MODE_CAP)
                        && !cnt_i.brk
                        && !cnt_i.halt
                        && !rlock_q[c]
                        && ((rise[c] && sc_q[c].edge_level_select[0])
                            || (fall[c] && sc_q[c].edge_level_select[1]));
            cmpval[c] = (mode_w[c] == TCC_MODE_BUFF) ? val_q[bsel_q] : val_q[c];
            hit[c] = cnt_i.tick && (cnt_i.value == cmpval[c])
                     && ((mode_w[c] == TCC_MODE_CMP) || (mode_w[c] == TCC_MODE_BUFF)
                         || ((mode_w[c] == TCC_MODE_PRESET) && sc_q[c].mode_select_low))
                     && !(wlock_q[c] || ((mode_w[c] == TCC_MODE_BUFF) && wlock_q[1]));
            wrap_ev[c] = cnt_i.tick && cnt_i.wrap
                         && ((mode_w[c] == TCC_MODE_CMP) || (mode_w[c] == TCC_MODE_BUFF));
        end
    end

    // next state for registers, locks and pins; hardware events win over bus
    always_comb begin
        sc_d    = sc_q;
        val_d   = val_q;
        armed_d = armed_q;
        rlock_d = rlock_q;
        wlock_d = wlock_q;
        fmax_d  = fmax_q;
        out_d   = pin_out;
        oe_d    = pin_oe;
        bsel_d  = bsel_q;
        lvl_d   = lvl_q;
        irq_d   = irq;
        ack_d   = req;
        dat_d   = 32'h0000_0000;
        for (int c = 0; c < 2; c++) begin
            logic sc_sel;
            logic vh_sel;
            logic vl_sel;
            sc_sel = (wb_adr_i == ((c == 1) ? ADR_SC1 : ADR_SC0)) && !((c == 1) && buf0);
            vh_sel = (wb_adr_i == ((c == 1) ? ADR_V1H : ADR_V0H));
            vl_sel = (wb_adr_i == ((c == 1) ? ADR_V1L : ADR_V0L));
            if (s2_q[c] == s3_q[c]) begin
                lvl_d[c] = s3_q[c];
            end
            // read data; a disabled control register reads as zero
            if (req && sc_sel) begin
                dat_d[7:0] = sc_q[c];
            end
            if (req && vh_sel) begin
                dat_d[7:0] = val_q[c][15:8];
            end
            if (req && vl_sel) begin
                dat_d[7:0] = val_q[c][7:0];
            end
            if (rd && sc_sel && sc_q[c].channel_event_flag) begin
                armed_d[c] = 1'b1;
            end
            if (wr && sc_sel) begin
                sc_d[c] = wd;
                sc_d[c].channel_event_flag = sc_q[c].channel_event_flag
                                             & ~(armed_q[c] & ~wd.channel_event_flag);
                if (c == 1) begin
                    sc_d[c].buffered_mode_select = 1'b0;
                end
                armed_d[c] = 1'b0;
            end
            if (rd && vh_sel && (mode_w[c] == TCC_MODE_CAP)) begin
                rlock_d[c] = 1'b1;
            end
            if (rd && vl_sel) begin
                rlock_d[c] = 1'b0;
            end
            if (wr && vh_sel) begin
                val_d[c][15:8] = wb_dat_i[7:0];
                if (sc_q[c].buffered_mode_select || sc_q[c].mode_select_low
                    || ((c == 1) && buf0)) begin
                    wlock_d[c] = 1'b1;
                end
            end
            if (wr && vl_sel) begin
                val_d[c][7:0] = wb_dat_i[7:0];
                wlock_d[c]    = 1'b0;
            end
            if (cap_ev[c]) begin
                val_d[c] = cnt_i.value;
            end
            if (cap_ev[c] || hit[c]) begin
                sc_d[c].channel_event_flag = 1'b1;
                armed_d[c] = 1'b0;
            end
            // pin behaviour per mode
            case (mode_w[c])
                TCC_MODE_PRESET: begin
                    out_d[c]  = ~sc_q[c].mode_select_low;
                    oe_d[c]   = 1'b0;
                    fmax_d[c] = 1'b0;
                end
                TCC_MODE_CMP, TCC_MODE_BUFF: begin
                    oe_d[c] = 1'b1;
                    if (wrap_ev[c]) begin
                        fmax_d[c] = sc_q[c].toggle_on_wrap & sc_q[c].full_duty_force;
                    end
                    if (wrap_ev[c] && sc_q[c].toggle_on_wrap) begin
                        if (fmax_q[c]) begin
                            out_d[c] = (sc_q[c].edge_level_select != ELS_BOTH);
                        end else begin
                            out_d[c] = ~pin_out[c];
                        end
                    end else if (hit[c] && !fmax_q[c]) begin
                        case (sc_q[c].edge_level_select)
                            ELS_RISE: out_d[c] = ~pin_out[c];
                            ELS_FALL: out_d[c] = 1'b0;
                            ELS_BOTH: out_d[c] = 1'b1;
                            default:  out_d[c] = pin_out[c];
                        endcase
                    end
                end
                TCC_MODE_CAP, TCC_MODE_OFF: begin
                    oe_d[c]   = 1'b0;
                    fmax_d[c] = 1'b0;
                end
                default: begin
                    oe_d[c] = 1'b0;
                end
            endcase
            irq_d[c] = sc_d[c].channel_irq_enable & sc_d[c].channel_event_flag;
        end
        if (mode_w[0] != TCC_MODE_BUFF) begin
            bsel_d = 1'b0;
        end else if (wrap_ev[0]) begin
            bsel_d = ~bsel_q;
        end
    end

    // three-stage pin synchroniser; stage one feeds only stage two
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 2'b00;
            s2_q <= 2'b00;
            s3_q <= 2'b00;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // state registers; the clock enable freezes everything while low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sc_q[0]  <= tcc_sc_t'(SC_RESET);
            sc_q[1]  <= tcc_sc_t'(SC_RESET);
            // contents are undefined to software; zero keeps simulation clean
            val_q[0] <= VAL_RESET;
            val_q[1] <= VAL_RESET;
            armed_q  <= 2'b00;
            rlock_q  <= 2'b00;
            wlock_q  <= 2'b00;
            fmax_q   <= 2'b00;
            pin_out  <= 2'b00;
            pin_oe   <= 2'b00;
            bsel_q   <= 1'b0;
            lvl_q    <= 2'b00;
            irq      <= 2'b00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            sc_q     <= sc_d;
            val_q    <= val_d;
            armed_q  <= armed_d;
            rlock_q  <= rlock_d;
            wlock_q  <= wlock_d;
            fmax_q   <= fmax_d;
            pin_out  <= out_d;
            pin_oe   <= oe_d;
            bsel_q   <= bsel_d;
            lvl_q    <= lvl_d;
            irq      <= irq_d;
            wb_ack_o <= ack_d;
            wb_dat_o <= dat_d;
        end
    end

    // checks on the channel logic
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_cap_flag_set: assert property (ce && cap_ev[0] |=> sc_q[0].channel_event_flag)
        else $error("capture did not set channel 0 flag");
    chk_hit_flag_set: assert property (ce && hit[1] |=> sc_q[1].channel_event_flag)
        else $error("compare did not set channel 1 flag");
    chk_event_beats_clear: assert property (ce && (cap_ev[0] || hit[0]) && wr
        && wb_adr_i == ADR_SC0 |=> sc_q[0].channel_event_flag)
        else $error("zero write lost a new event");
    chk_one_write_keeps: assert property (ce && wr && wb_adr_i == ADR_SC0
        && !sc_q[0].channel_event_flag && !cap_ev[0] && !hit[0]
        |=> !sc_q[0].channel_event_flag)
        else $error("writing flag set it");
    chk_irq_gate: assert property (irq[0] == (sc_q[0].channel_irq_enable
        && sc_q[0].channel_event_flag))
        else $error("interrupt not gated by enable and flag");
    chk_ch1_freed: assert property (buf0 && $past(buf0) && $past(ce) |-> !pin_oe[1])
        else $error("channel 1 drives pin while buffered");
    chk_preset_level: assert property (ce && mode_w[0] == TCC_MODE_PRESET
        |=> !pin_oe[0] && pin_out[0] == !$past(sc_q[0].mode_select_low))
        else $error("preset level or pin release wrong");
    chk_wrap_wins: assert property (ce && wrap_ev[1] && hit[1] && sc_q[1].toggle_on_wrap
        && !fmax_q[1] |=> pin_out[1] != $past(pin_out[1]))
        else $error("overflow toggle lost to compare");
    chk_read_lock: assert property (rlock_q[0] |-> !cap_ev[0])
        else $error("capture while high byte lock held");
    chk_write_lock: assert property (ce && wlock_q[1] && !(wr && wb_adr_i == ADR_V1L)
        |=> !hit[1] || !sc_q[1].mode_select_low || wlock_q[1])
        else $error("write lock released early");
    chk_halt_blocks: assert property ((cnt_i.halt || cnt_i.brk) |-> cap_ev == 2'b00)
        else $error("capture while counter halted");

    // pin actions, value storage, buffering and channel 1 interrupt
    chk_soft_cmp_flag: assert property (ce && hit[1] && mode_w[1] == TCC_MODE_PRESET
        |=> sc_q[1].channel_event_flag && !pin_oe[1])
        else $error("flag-only compare missed flag or drove pin");
    chk_wrap_toggle: assert property (ce && wrap_ev[1] && sc_q[1].toggle_on_wrap
        && !fmax_q[1] |=> pin_out[1] != $past(pin_out[1]))
        else $error("pin did not toggle at counter wrap");
    chk_full_duty: assert property (ce && wrap_ev[1] && sc_q[1].toggle_on_wrap
        && fmax_q[1] |=> pin_out[1] == ($past(sc_q[1].edge_level_select) != ELS_BOTH))
        else $error("full duty level wrong at wrap");
    chk_ch1_regs_off: assert property (ce && buf0 && rd && wb_adr_i == ADR_SC1
        |=> wb_dat_o == 32'h0000_0000)
        else $error("channel 1 control readable while buffered");
    chk_capture_pin_free: assert property (ce && mode_w[0] == TCC_MODE_CAP
        |=> !pin_oe[0])
        else $error("capture channel drives its pin");
    chk_irq_gate_ch1: assert property (irq[1] == (sc_q[1].channel_irq_enable
        && sc_q[1].channel_event_flag))
        else $error("channel 1 interrupt not gated");
    chk_cap_value: assert property (ce && cap_ev[0]
        |=> val_q[0] == $past(cnt_i.value))
        else $error("capture stored wrong counter value");
    chk_buf_swap: assert property (ce && wrap_ev[0] && mode_w[0] == TCC_MODE_BUFF
        |=> bsel_q != $past(bsel_q))
        else $error("buffered compare value did not swap");

    cov_capture: cover property (ce && cap_ev[0] ##1 irq[0]);
    cov_buffered_hit: cover property (ce && hit[0] && mode_w[0] == TCC_MODE_BUFF);
    cov_flag_cleared: cover property (sc_q[1].channel_event_flag ##1
        !sc_q[1].channel_event_flag);
    cov_full_duty: cover property (ce && wrap_ev[1] && fmax_q[1]);
    cov_soft_compare: cover property (ce && hit[1] && mode_w[1] == TCC_MODE_PRESET);

endmodule : tcc_capture_compare

// ---- verif/tcc_pin_model.sv ----
/*
 * far-side model of the two channel pins: the outside party drives a pin
 * whenever the block leaves it, and the wire follows the block otherwise.
 * assumes level commands arrive just after a rising mclk edge.
 */
`timescale 1ns/100ps

module tcc_pin_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [1:0] drv_lvl,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic      [1:0] pin_in
);
    logic [1:0] ext_q;

    // whole-cycle levels
    // levels move only at an edge so a pin never glitches mid-cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 2'b00;
        end else begin
            ext_q <= drv_lvl;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_q[i];
        end
    end
endmodule : tcc_pin_model

// ---- verif/tcc_capture_compare_tb.sv ----
/*
 * self-checking bench for the capture/compare block: wishbone tasks,
 * a counter bundle driven here, and the pin model on the channel pins.
 * assumes the counter lives outside the block; ce is high but for one freeze test.
 */
`timescale 1ns/100ps

module tcc_capture_compare_tb;
    import tcc_pkg::*;

    logic        mclk, rst_n, ce, cyc, stb, we, ack;
    logic [7:0]  adr, q;
    logic [31:0] dat_w, dat_r;
    logic [1:0]  lvl, p_in, p_out, p_oe, irq;
    tcc_cnt_t    cnt;
    int          bad_count = 0, compares = 0, cycles = 0;
    logic [7:0]  regs [7] = '{ADR_SC0, ADR_SC1, ADR_V0H, ADR_V0L, ADR_V1H, ADR_V1L, 8'h18};

    tcc_capture_compare u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .cnt_i(cnt), .pin_in(p_in), .pin_out(p_out),
        .pin_oe(p_oe), .irq(irq));
    tcc_pin_model u_pins (.mclk(mclk), .rst_n(rst_n), .drv_lvl(lvl), .pin_out(p_out),
        .pin_oe(p_oe), .pin_in(p_in));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // cut a hang short; the whole run needs fewer than a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; entered just after an edge, waits for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= {24'h000000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) chk({7'h00, ack}, 8'h01);
        @(posedge mclk);
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rchk

    // arm by reading with the flag set, then write the flag low
    task automatic clr(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
        bus(1'b1, a, q & 8'h7f);
    endtask : clr

    // counter takes a new value and ticks (with optional wrap) for one cycle
    task automatic tk(input logic [15:0] v, input logic w);
        cnt.value <= v;
        cnt.tick  <= 1'b1;
        cnt.wrap  <= w;
        @(posedge mclk);
        cnt.tick <= 1'b0;
        cnt.wrap <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : tk

    // allow for the synchroniser before looking at the result
    task automatic pinl(input logic [1:0] l);
        lvl <= l;
        repeat (8) @(posedge mclk);
    endtask : pinl

    task automatic po1(input logic [1:0] e);
        repeat (2) @(posedge mclk);
        chk({6'h00, p_oe[1], p_out[1]}, {6'h00, e});
    endtask : po1

    task automatic summarize();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        logic fl;
        rst_n = 1'b0;
        {cyc, stb, we, adr, dat_w, lvl} = '0;
        ce = 1'b1;
        cnt = '0;
        cnt.halt = 1'b1;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 7; i++) rchk(regs[i], i < 2 ? SC_RESET : VAL_RESET[7:0]);
        chk({4'h0, irq, p_oe}, 8'h00);
        $display("test reset done");
        // every capture code against both edge directions
        for (int e = 1; e < 4; e++) begin
            for (int f = 0; f < 2; f++) begin
                cnt.halt <= 1'b1;
                pinl({1'b0, f[0]});
                bus(1'b1, ADR_SC0, {4'h4, e[1:0], 2'b00});
                clr(ADR_SC0);
                cnt.halt  <= 1'b0;
                cnt.value <= {8'h5a, 5'h00, e[1:0], f[0]};
                pinl({1'b0, ~f[0]});
                fl = f[0] ? e[1] : e[0];
                rchk(ADR_SC0, {fl, 3'b100, e[1:0], 2'b00});
                chk({6'h00, irq}, {7'h00, fl});
                if (fl) rchk(ADR_V0H, 8'h5a);
                if (fl) rchk(ADR_V0L, {5'h00, e[1:0], f[0]});
            end
        end
        $display("test capture edges done");
        cnt.halt <= 1'b1;
        bus(1'b1, ADR_SC0, 8'h4c);
        clr(ADR_SC0);
        for (int k = 0; k < 2; k++) begin
            cnt.halt <= (k == 0);
            cnt.brk  <= (k == 1);
            pinl({1'b0, ~lvl[0]});
            rchk(ADR_SC0, 8'h4c);
        end
        cnt.brk <= 1'b0;
        pinl({1'b0, ~lvl[0]});
        rchk(ADR_SC0, 8'hcc);
        $display("test capture inhibit done");
        cnt.value <= 16'h1122;
        pinl({1'b0, ~lvl[0]});
        rchk(ADR_V0H, 8'h11);
        cnt.value <= 16'h3344;
        pinl({1'b0, ~lvl[0]});
        rchk(ADR_V0L, 8'h22);
        pinl({1'b0, ~lvl[0]});
        rchk(ADR_V0H, 8'h33);
        rchk(ADR_V0L, 8'h44);
        $display("test read lock done");
        bus(1'b1, ADR_SC0, 8'h4c);
        rchk(ADR_SC0, 8'hcc);
        pinl({1'b0, ~lvl[0]});
        bus(1'b1, ADR_SC0, 8'h4c);
        rchk(ADR_SC0, 8'hcc);
        bus(1'b1, ADR_SC0, 8'h4c);
        rchk(ADR_SC0, 8'h4c);
        chk({6'h00, irq}, 8'h00);
        bus(1'b1, ADR_SC0, 8'hcc);
        rchk(ADR_SC0, 8'h4c);
        $display("test flag clear done");
        cnt.halt <= 1'b1;
        bus(1'b1, ADR_SC1, 8'h10);
        po1(2'b00);
        bus(1'b1, ADR_SC1, 8'h00);
        po1(2'b01);
        bus(1'b1, ADR_V1H, 8'h00);
        bus(1'b1, ADR_V1L, 8'h50);
        // set, clear, toggle, then flag only
        for (int j = 3; j >= 0; j--) begin
            cnt.halt <= 1'b1;
            bus(1'b1, ADR_SC1, {4'h1, j[1:0], 2'b00});
            clr(ADR_SC1);
            cnt.halt <= 1'b0;
            tk(16'h0051, 1'b0);
            rchk(ADR_SC1, {4'h1, j[1:0], 2'b00});
            tk(16'h0050, 1'b0);
            rchk(ADR_SC1, {4'h9, j[1:0], 2'b00});
            if (j != 0) po1({1'b1, j != 2});
            else chk({7'h00, p_oe[1]}, 8'h00);
        end
        $display("test compare codes done");
        bus(1'b1, ADR_SC1, 8'h14);
        clr(ADR_SC1);
        bus(1'b1, ADR_V1H, 8'h00);
        tk(16'h0050, 1'b0);
        rchk(ADR_SC1, 8'h14);
        bus(1'b1, ADR_V1L, 8'h50);
        tk(16'h0050, 1'b0);
        rchk(ADR_SC1, 8'h94);
        $display("test write lock done");
        bus(1'b1, ADR_SC1, 8'h1e);
        tk(16'h0050, 1'b0);
        po1(2'b11);
        bus(1'b1, ADR_SC1, 8'h16);
        tk(16'h0050, 1'b1);
        po1(2'b10);
        tk(16'h0010, 1'b1);
        po1(2'b11);
        bus(1'b1, ADR_SC1, 8'h1b);
        tk(16'h0010, 1'b1);
        tk(16'h0010, 1'b1);
        tk(16'h0050, 1'b0);
        po1(2'b11);
        bus(1'b1, ADR_SC1, 8'h1a);
        tk(16'h0010, 1'b1);
        tk(16'h0050, 1'b0);
        po1(2'b10);
        $display("test wrap and full duty done");
        cnt.halt <= 1'b1;
        bus(1'b1, ADR_SC0, 8'h2c);
        rchk(ADR_SC1, 8'h00);
        bus(1'b1, ADR_SC1, 8'h1c);
        rchk(ADR_SC1, 8'h00);
        for (int i = 2; i < 6; i++) bus(1'b1, regs[i], (i % 2) ? 8'(8'h30 * (i - 2)) : 8'h00);
        clr(ADR_SC0);
        cnt.halt <= 1'b0;
        tk(16'h0060, 1'b0);
        rchk(ADR_SC0, 8'h2c);
        tk(16'h0030, 1'b0);
        rchk(ADR_SC0, 8'hac);
        chk({4'h0, p_oe, p_out}, 8'h05);
        clr(ADR_SC0);
        tk(16'h0010, 1'b1);
        tk(16'h0030, 1'b0);
        rchk(ADR_SC0, 8'h2c);
        tk(16'h0090, 1'b0);
        rchk(ADR_SC0, 8'hac);
        // a frozen clock enable must not let a matching tick through
        clr(ADR_SC0);
        ce <= 1'b0;
        tk(16'h0090, 1'b0);
        ce <= 1'b1;
        rchk(ADR_SC0, 8'h2c);
        $display("test buffered done");
        summarize();
    end
endmodule : tcc_capture_compare_tb
